// ### include/tpcl_pkg.sv
// Package: constants, types and helper functions of the trim profile controller
package tpcl_pkg;
    localparam int          NUM_CH        = 6;
    localparam int          ADDR_W        = 8;
    localparam int          ADC_W         = 10;
    localparam int          CNT_W         = 22;
    localparam real         CLK_PERIOD_NS = 5.0;
    // Correction intervals as printed, selected by the 2-bit update rate
    localparam real         T_RATE0_US    = 432.0;
    localparam real         T_RATE1_MS    = 1.06;
    localparam real         T_RATE2_MS    = 8.74;
    localparam real         T_RATE3_MS    = 16.9;
    // Register map: 8 words per channel, then a global block
    localparam logic [2:0]  CH_GLOBAL     = 3'h6;
    localparam logic [2:0]  LAST_CH       = 3'h5;
    localparam logic [2:0]  WORD_HOST     = 3'h4;
    localparam logic [2:0]  WORD_SETP     = 3'h5;
    localparam logic [2:0]  WORD_CFG      = 3'h6;
    localparam logic [2:0]  WORD_STAT     = 3'h7;
    localparam logic [2:0]  WORD_RATE     = 3'h0;
    localparam logic [2:0]  WORD_GSTAT    = 3'h1;
    localparam int          CFG_POL_BIT   = 2;
    localparam int          STAT_CL_LSB   = 8;
    localparam int          GST_CLEN_BIT  = 2;
    localparam int          GST_BUSY_BIT  = 3;
    // Reset values
    localparam logic [7:0]  CODE_ZERO     = 8'h80;
    localparam logic [ADC_W-1:0] SETP_RST = 10'h000;
    localparam logic [1:0]  RATE_RST      = 2'h0;
    // Profile-0 modes
    localparam logic [1:0]  MODE_FIXED0   = 2'h0;
    localparam logic [1:0]  MODE_HOST     = 2'h1;
    localparam logic [1:0]  MODE_CLOSED   = 2'h2;
    localparam logic [1:0]  PROFILE_0     = 2'h0;
    // Comparator outcomes: +1, -1, 0
    localparam logic [1:0]  CMP_UP        = 2'h1;
    localparam logic [1:0]  CMP_DN        = 2'h3;
    localparam logic [1:0]  CMP_EQ        = 2'h0;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    typedef struct packed {
        logic [3:0][7:0]  prof;
        logic [7:0]       host;
        logic [7:0]       cl;
        logic [ADC_W-1:0] setp;
        logic [1:0]       mode;
        logic             pol;
    } tpcl_chan_regs_t;

    typedef struct packed {
        logic       valid;
        logic [2:0] chan;
    } tpcl_adc_req_t;

    typedef struct packed {
        logic             valid;
        logic [ADC_W-1:0] data;
    } tpcl_adc_rsp_t;

    function automatic logic [1:0] tpcl_cmp(input logic [ADC_W-1:0] setp,
                                            input logic [ADC_W-1:0] meas);
        if (setp > meas) return CMP_UP;
        if (setp < meas) return CMP_DN;
        return CMP_EQ;
    endfunction

    function automatic logic [7:0] tpcl_step(input logic [7:0] c, input logic up);
        if (up) return (c == 8'hFF) ? c : c + 8'h01;
        return (c == 8'h00) ? c : c - 8'h01;
    endfunction

    function automatic logic [31:0] tpcl_merge(input logic [31:0] o, input logic [31:0] n,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) r[8*i +: 8] = n[8*i +: 8];
        end
        return r;
    endfunction
endpackage

// ### core/tpcl_channel.sv
// One trim channel: code registers, mode and profile selection, trim stepping
`timescale 1ns/10ps
`default_nettype none
module tpcl_channel
    import tpcl_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic             wr_en,
    input  wire logic [2:0]       wr_word,
    input  wire logic [31:0]      wr_data,
    input  wire logic [1:0]       profile_select,
    input  wire logic             step_en,
    input  wire logic [ADC_W-1:0] meas,
    output var  tpcl_chan_regs_t  regs_q,
    output logic      [7:0]       dac_code_q
);
    logic [1:0] cmp;
    logic       up;
    logic       move;
    logic       wr_host;
    logic [7:0] mode_code;
    logic [7:0] sel_code;

    assign cmp       = tpcl_cmp(regs_q.setp, meas);
    assign up        = (cmp == CMP_UP) ^ regs_q.pol;
    assign move      = step_en && (cmp != CMP_EQ);
    assign wr_host   = wr_en && (wr_word == WORD_HOST);
    assign mode_code = (regs_q.mode == MODE_HOST)   ? regs_q.host :
                       (regs_q.mode == MODE_CLOSED) ? regs_q.cl   : regs_q.prof[0];
    // Profile 1-3 overrides whatever mode profile 0 would use
    assign sel_code  = (profile_select != PROFILE_0) ? regs_q.prof[profile_select]
                                                     : mode_code;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            regs_q <= '{prof: {4{CODE_ZERO}}, host: CODE_ZERO, cl: CODE_ZERO,
                        setp: SETP_RST, mode: MODE_FIXED0, pol: 1'b0};
        end else begin
            // A host load beats a trim step in the same cycle
            if (wr_host) begin
                regs_q.host <= wr_data[7:0];
                regs_q.cl   <= wr_data[7:0];
            end else if (move) begin
                regs_q.cl   <= tpcl_step(regs_q.cl, up);
            end
            if (wr_en && !wr_word[2]) regs_q.prof[wr_word[1:0]] <= wr_data[7:0];
            if (wr_en && wr_word == WORD_SETP) regs_q.setp <= wr_data[ADC_W-1:0];
            if (wr_en && wr_word == WORD_CFG) begin
                regs_q.mode <= wr_data[1:0];
                regs_q.pol  <= wr_data[CFG_POL_BIT];
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) dac_code_q <= CODE_ZERO;
        else         dac_code_q <= sel_code;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_profile_route: assert property ((profile_select == 2'h3) |=>
        dac_code_q == $past(regs_q.prof[3])) else $error("profile 3 not routed");
    a_fixed_route: assert property ((profile_select == PROFILE_0 &&
        regs_q.mode == MODE_FIXED0) |=> dac_code_q == $past(regs_q.prof[0]))
        else $error("fixed register 0 not routed");
    a_host_route: assert property ((profile_select == PROFILE_0 &&
        regs_q.mode == MODE_HOST) |=> dac_code_q == $past(regs_q.host))
        else $error("host register not routed");
    a_cl_hold: assert property (!(move || wr_host) |=> $stable(regs_q.cl))
        else $error("trim register moved without a step");
    a_cl_step: assert property ((move && !wr_host && up && regs_q.cl != 8'hFF) |=>
        regs_q.cl == $past(regs_q.cl) + 8'h01) else $error("trim step up wrong");
    a_cl_sat: assert property ((move && !wr_host && !up && regs_q.cl == 8'h00) |=>
        regs_q.cl == 8'h00) else $error("trim register wrapped below zero");
    c_cl_step: cover property (move && !wr_host);
    c_prof3: cover property (profile_select == 2'h3 ##1 profile_select == PROFILE_0);
endmodule
`default_nettype wire

// ### core/tpcl_top.sv
// Top: AXI4-Lite register file, input synchronisers, correction sequencer, six trim channels
//
// Overview of operation
// - Both profile-select pins form one selection shared by all six channels.
// - Select 11, 10, 01 routes profile register 3, 2, 1 to every DAC.
// - Select 00: each channel runs its own configured mode.
// - Fixed mode under profile 0 drives profile register 0 to the DAC.
// - Host mode follows a host-written code register that resets to 80h.
// - Each channel holds four profile codes plus host and trim codes.
// - Mode mux and profile mux per channel route the code to the DAC.
// - One active-low enable starts trimming on all closed-loop channels together.
// - Each closed-loop channel compares against its own stored setpoint.
// - Each interval a correction cycle measures the channel through the ADC.
// - Comparison yields +1, -1 or 0 for setpoint above, below, equal.
// - Trim code steps per outcome and polarity; outcome 0 leaves it.
// - Polarity decides whether +1 increments or decrements; -1 does the opposite.
// - Rate 00/01/10/11 gives 432 us, 1.06 ms, 8.74 ms, 16.9 ms.
// - Enable released: finish the running cycle, then hold the trim code.
// - Any nonzero profile select pauses trimming exactly like releasing enable.
// - Trim code resets to 80h; host code writes also load it.
`timescale 1ns/10ps
`default_nettype none
module tpcl_top
    import tpcl_pkg::*;
#(
    parameter int RATE_CYC0 = int'(T_RATE0_US * 1000.0 / CLK_PERIOD_NS),
    parameter int RATE_CYC1 = int'(T_RATE1_MS * 1000000.0 / CLK_PERIOD_NS),
    parameter int RATE_CYC2 = int'(T_RATE2_MS * 1000000.0 / CLK_PERIOD_NS),
    parameter int RATE_CYC3 = int'(T_RATE3_MS * 1000000.0 / CLK_PERIOD_NS)
)
(
    input  wire logic                         clk,
    input  wire logic                         arst_n,
    input  wire logic [1:0]                   profile_select,
    input  wire logic                         closed_loop_enable_n,
    input  wire logic                         s_axi_awvalid,
    output logic                              s_axi_awready,
    input  wire logic [ADDR_W-1:0]            s_axi_awaddr,
    input  wire logic                         s_axi_wvalid,
    output logic                              s_axi_wready,
    input  wire logic [31:0]                  s_axi_wdata,
    input  wire logic [3:0]                   s_axi_wstrb,
    output logic                              s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    output logic      [1:0]                   s_axi_bresp,
    input  wire logic                         s_axi_arvalid,
    output logic                              s_axi_arready,
    input  wire logic [ADDR_W-1:0]            s_axi_araddr,
    output logic                              s_axi_rvalid,
    input  wire logic                         s_axi_rready,
    output logic      [31:0]                  s_axi_rdata,
    output logic      [1:0]                   s_axi_rresp,
    output var  tpcl_adc_req_t                adc_req_q,
    input  wire tpcl_adc_rsp_t                adc_rsp,
    output logic      [NUM_CH-1:0][7:0]       dac_code
);
    typedef enum logic [1:0] {
        SQ_IDLE = 2'b00,
        SQ_SCAN = 2'b01,
        SQ_WAIT = 2'b10,
        SQ_NEXT = 2'b11
    } tpcl_seq_t;

    // Synchronisers
    logic [1:0]             psel_m_q;
    logic [1:0]             psel_s_q;
    logic                   en_n_m_q;
    logic                   en_n_s_q;
    // Bus slave state
    logic                   awready_q;
    logic                   wready_q;
    logic                   bvalid_q;
    logic [1:0]             bresp_q;
    logic                   arready_q;
    logic                   rvalid_q;
    logic [31:0]            rdata_q;
    logic [1:0]             rresp_q;
    logic                   aw_got_q;
    logic                   w_got_q;
    logic [ADDR_W-1:0]      awaddr_q;
    logic [31:0]            wdata_q;
    logic [3:0]             wstrb_q;
    // Global registers and sequencer
    logic [1:0]             rate_q;
    logic [CNT_W-1:0]       cnt_q;
    logic [CNT_W-1:0]       cnt_d;
    tpcl_seq_t              seq_q;
    tpcl_seq_t              seq_d;
    logic [2:0]             seq_ch_q;
    logic [2:0]             seq_ch_d;
    tpcl_adc_req_t          adc_req_d;
    // Channel side
    tpcl_chan_regs_t        regs [NUM_CH];
    logic [NUM_CH-1:0]      step_vec;
    logic [NUM_CH-1:0]      wr_vec;

    // Decoding and selection
    logic                   aw_take;
    logic                   w_take;
    logic                   ar_take;
    logic                   wr_fire;
    logic                   wr_ok;
    logic [2:0]             wr_ch;
    logic [2:0]             wr_word;
    logic [31:0]            wr_val;
    logic                   wr_rate;
    logic                   cl_active;
    logic                   tick;
    logic                   seq_busy;
    logic                   ch_is_cl;
    logic                   adc_back;
    logic [CNT_W-1:0]       interval_m1;

    function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
        return (a[7:5] < CH_GLOBAL) ||
               (a[7:5] == CH_GLOBAL && (a[4:2] == WORD_RATE || a[4:2] == WORD_GSTAT));
    endfunction

    function automatic logic [31:0] rd_word(input logic [ADDR_W-1:0] a);
        logic [31:0]     r;
        tpcl_chan_regs_t c;
        r = 32'h0000_0000;
        c = regs[0];
        if (a[7:5] < CH_GLOBAL) begin
            c = regs[a[7:5]];
            if (!a[4]) begin
                r[7:0] = c.prof[a[3:2]];
            end else begin
                case (a[4:2])
                    WORD_HOST: r[7:0] = c.host;
                    WORD_SETP: r[ADC_W-1:0] = c.setp;
                    WORD_CFG:  r[CFG_POL_BIT:0] = {c.pol, c.mode};
                    default:   r[15:0] = {c.cl, dac_code[a[7:5]]};
                endcase
            end
        end else if (a[7:5] == CH_GLOBAL && a[4:2] == WORD_RATE) begin
            r[1:0] = rate_q;
        end else if (a[7:5] == CH_GLOBAL && a[4:2] == WORD_GSTAT) begin
            r[GST_BUSY_BIT:0] = {seq_busy, cl_active, psel_s_q};
        end
        return r;
    endfunction

    // Outputs straight from flops
    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    // Pins are asynchronous to clk; only the second stage is read
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            psel_m_q <= PROFILE_0;
            psel_s_q <= PROFILE_0;
            en_n_m_q <= 1'b1;
            en_n_s_q <= 1'b1;
        end else begin
            psel_m_q <= profile_select;
            psel_s_q <= psel_m_q;
            en_n_m_q <= closed_loop_enable_n;
            en_n_s_q <= en_n_m_q;
        end
    end

    // Write path: address and data taken in either order, answered when both held
    assign aw_take = s_axi_awvalid && awready_q;
    assign w_take  = s_axi_wvalid && wready_q;
    assign ar_take = s_axi_arvalid && arready_q;
    assign wr_fire = aw_got_q && w_got_q && !bvalid_q;
    assign wr_ok   = addr_ok(awaddr_q);
    assign wr_ch   = awaddr_q[7:5];
    assign wr_word = awaddr_q[4:2];
    // Merge keeps the unstrobed bytes of the current contents
    assign wr_val  = tpcl_merge(rd_word(awaddr_q), wdata_q, wstrb_q);
    assign wr_rate = wr_fire && wr_ch == CH_GLOBAL && wr_word == WORD_RATE;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            aw_got_q  <= 1'b0;
            w_got_q   <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_got_q  <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
                awready_q <= 1'b0;
            end
            if (w_take) begin
                w_got_q  <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
                wready_q <= 1'b0;
            end
            if (wr_fire) begin
                aw_got_q <= 1'b0;
                w_got_q  <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid_q && s_axi_bready) begin
                bvalid_q  <= 1'b0;
                awready_q <= 1'b1;
                wready_q  <= 1'b1;
            end
        end
    end

    // Read path: one read at a time, answered at the edge after the address
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= RESP_OKAY;
        end else if (ar_take) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= rd_word(s_axi_araddr);
            rresp_q   <= addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)      rate_q <= RATE_RST;
        else if (wr_rate) rate_q <= wr_val[1:0];
    end

    // Interval timer runs freely; a new rate applies from the next reload
    assign interval_m1 = (rate_q == 2'h0) ? CNT_W'(RATE_CYC0 - 1) :
                         (rate_q == 2'h1) ? CNT_W'(RATE_CYC1 - 1) :
                         (rate_q == 2'h2) ? CNT_W'(RATE_CYC2 - 1) : CNT_W'(RATE_CYC3 - 1);
    assign tick  = (cnt_q == '0);
    assign cnt_d = tick ? interval_m1 : cnt_q - CNT_W'(1);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) cnt_q <= '0;
        else         cnt_q <= cnt_d;
    end

    // Shared enable and shared profile gate only the start of a cycle
    assign cl_active = !en_n_s_q && (psel_s_q == PROFILE_0);
    assign seq_busy  = (seq_q != SQ_IDLE);
    assign ch_is_cl  = (regs[seq_ch_q].mode == MODE_CLOSED);
    assign adc_back  = (seq_q == SQ_WAIT) && adc_rsp.valid;

    always_comb begin
        seq_d     = seq_q;
        seq_ch_d  = seq_ch_q;
        adc_req_d = '{valid: 1'b0, chan: seq_ch_q};
        unique case (seq_q)
            SQ_IDLE: begin
                if (tick && cl_active) begin
                    seq_d    = SQ_SCAN;
                    seq_ch_d = 3'h0;
                end
            end
            SQ_SCAN: begin
                if (ch_is_cl) begin
                    seq_d           = SQ_WAIT;
                    adc_req_d.valid = 1'b1;
                end else begin
                    seq_d = SQ_NEXT;
                end
            end
            SQ_WAIT: begin
                if (adc_rsp.valid) seq_d = SQ_NEXT;
            end
            SQ_NEXT: begin
                // The cycle runs over all channels even if trimming was paused meanwhile
                if (seq_ch_q == LAST_CH) begin
                    seq_d = SQ_IDLE;
                end else begin
                    seq_d    = SQ_SCAN;
                    seq_ch_d = seq_ch_q + 3'h1;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            seq_q     <= SQ_IDLE;
            seq_ch_q  <= 3'h0;
            adc_req_q <= '{valid: 1'b0, chan: 3'h0};
        end else begin
            seq_q     <= seq_d;
            seq_ch_q  <= seq_ch_d;
            adc_req_q <= adc_req_d;
        end
    end

    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        assign wr_vec[i]   = wr_fire && (wr_ch == 3'(i));
        assign step_vec[i] = adc_back && (seq_ch_q == 3'(i));
        tpcl_channel u_ch (
            .clk            (clk),
            .arst_n         (arst_n),
            .wr_en          (wr_vec[i]),
            .wr_word        (wr_word),
            .wr_data        (wr_val),
            .profile_select (psel_s_q),
            .step_en        (step_vec[i]),
            .meas           (adc_rsp.data),
            .regs_q         (regs[i]),
            .dac_code_q     (dac_code[i])
        );
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_start_gate: assert property ((seq_q == SQ_IDLE && !cl_active) |=>
        seq_q == SQ_IDLE) else $error("correction cycle started while paused");
    a_cycle_finish: assert property ((seq_q == SQ_NEXT && seq_ch_q != LAST_CH) |=>
        (seq_q == SQ_SCAN && seq_ch_q == $past(seq_ch_q) + 3'h1))
        else $error("correction cycle not finished");
    a_rate_reload: assert property ((tick && rate_q == 2'h0) |=>
        cnt_q == CNT_W'(RATE_CYC0 - 1)) else $error("interval reload wrong");
    a_req_pulse: assert property (adc_req_q.valid |->
        (seq_q == SQ_WAIT && regs[adc_req_q.chan].mode == MODE_CLOSED) ##1 !adc_req_q.valid)
        else $error("measurement request malformed");
    a_sync_two: assert property ((psel_s_q != $past(psel_s_q)) |->
        psel_s_q == $past(profile_select, 2)) else $error("select not two flops deep");
    a_bvalid_hold: assert property ((bvalid_q && !s_axi_bready) |=> bvalid_q)
        else $error("write response dropped");
    a_rd_slverr: assert property ((ar_take && !addr_ok(s_axi_araddr)) |=>
        (rvalid_q && rresp_q == RESP_SLVERR && rdata_q == 32'h0000_0000))
        else $error("unmapped read not refused");
    c_adc_round: cover property (adc_req_q.valid ##[1:20] adc_back);
    c_axi_write: cover property (wr_fire && wr_ok);
    c_pause: cover property (seq_busy && !cl_active);
endmodule
`default_nettype wire

// ### test/tpcl_adc_model.sv
// ADC stand-in: answers each request after a set latency
`timescale 1ns/10ps
`default_nettype none
module tpcl_adc_model
    import tpcl_pkg::*;
(
    input  wire logic             clk,
    input  wire tpcl_adc_req_t    req,
    input  wire logic [ADC_W-1:0] level,
    input  wire logic [3:0]       lat,
    output var  tpcl_adc_rsp_t    rsp
);
    logic [3:0] cnt_q = 4'h0;
    logic       busy_q = 1'h0;
    initial rsp = '0;
    always @(posedge clk) begin
        rsp.valid <= 1'h0;
        rsp.data  <= ~rsp.data; // Data is not held outside the pulse
        cnt_q     <= cnt_q - 4'h1;
        if (req.valid) begin
            busy_q <= 1'h1;
            cnt_q  <= lat;
        end else if (busy_q && cnt_q == 4'h0) begin
            busy_q <= 1'h0;
            rsp    <= {1'h1, level};
        end
    end
endmodule
`default_nettype wire

// ### test/tb_tpcl_top.sv
// Self-checking bench for the trim profile controller
`timescale 1ns/10ps
`default_nettype none
module tb_tpcl_top
    import tpcl_pkg::*;
;
    logic clk, arst_n, clen_n, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] psel, bresp, rresp, r;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd_q;
    logic [3:0] lat;
    logic [ADC_W-1:0] level;
    tpcl_adc_req_t req;
    tpcl_adc_rsp_t rsp;
    logic [NUM_CH-1:0][7:0] dac;
    int num_errors = 0, checked = 0, n;
    tpcl_top #(.RATE_CYC0(64), .RATE_CYC1(96), .RATE_CYC2(128), .RATE_CYC3(200)) dut (
        .clk(clk), .arst_n(arst_n), .profile_select(psel), .closed_loop_enable_n(clen_n),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .adc_req_q(req), .adc_rsp(rsp),
        .dac_code(dac));
    tpcl_adc_model adc (.clk(clk), .req(req), .level(level), .lat(lat), .rsp(rsp));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {awvalid, wvalid, bready, awaddr, wdata} <= {3'h7, a, d};
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        {arvalid, rready, araddr} <= {2'h3, a};
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        {rd_q, r} = {rdata, rresp};
        rready <= 1'h0;
    endtask
    // Cycles to the next request, 400 if none comes
    task automatic wait_req(output int c);
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (!req.valid && c < 400);
    endtask
    task automatic step(input logic [7:0] e);
        wait_req(n);
        chk("chan", 32'h0, 32'(req.chan));
        repeat (14) @(posedge clk);
        chk("trim", 32'(e), 32'(dac[0]));
    endtask
    task automatic t_reset;
        for (int c = 0; c < NUM_CH; c++) chk("dac", 32'h80, 32'(dac[c]));
        rd(8'h10);
        chk("host", 32'h80, rd_q);
        rd(8'h1C);
        chk("status", 32'h8080, rd_q);
        rd(8'hFC);
        chk("resp", 32'(RESP_SLVERR), 32'(r));
        wr(8'hFC, 32'h0000_00FF);
        chk("bresp", 32'(RESP_SLVERR), 32'(r));
    endtask
    task automatic t_profiles;
        for (int c = 0; c < NUM_CH; c++)
            for (int k = 0; k < 4; k++) wr(8'(c * 32 + k * 4), 32'(16 * k + c + 1));
        for (int k = 3; k >= 0; k--) begin
            psel <= 2'(k);
            repeat (5) @(posedge clk);
            for (int c = 0; c < NUM_CH; c++) chk("prof", 32'(16 * k + c + 1), 32'(dac[c]));
        end
    endtask
    task automatic t_host;
        wr(8'h30, 32'h5A);
        chk("bresp", 32'(RESP_OKAY), 32'(r));
        wr(8'h38, 32'(MODE_HOST));
        repeat (3) @(posedge clk);
        chk("host", 32'h5A, 32'(dac[1]));
        chk("fixed", 32'h01, 32'(dac[0]));
    endtask
    task automatic t_closed;
        level <= 10'h080;
        wr(8'h14, 32'h100);
        wr(8'h10, 32'hFE);
        wr(8'h18, 32'(MODE_CLOSED));
        clen_n <= 1'h0;
        step(8'hFF);
        step(8'hFF);
        wr(8'h18, 32'h6);
        step(8'hFE);
        level <= 10'h100;
        step(8'hFE);
        level <= 10'h180;
        step(8'hFF);
    endtask
    task automatic t_rates;
        int per[4] = '{64, 96, 128, 200};
        for (int i = 0; i < 4; i++) begin
            lat <= 4'(i * 3);
            wr(8'hC0, 32'(i));
            repeat (3) wait_req(n);
            chk("interval", 32'(per[i]), 32'(n));
        end
    endtask
    task automatic t_pause;
        // The cycle already running still steps down once before the pause
        {clen_n, level} <= {1'h1, 10'h080};
        repeat (30) @(posedge clk);
        wait_req(n);
        chk("idle", 32'h190, 32'(n));
        chk("held", 32'hFE, 32'(dac[0]));
        {clen_n, psel} <= 3'h1;
        repeat (30) @(posedge clk);
        wait_req(n);
        chk("idle", 32'h190, 32'(n));
        chk("prof", 32'h11, 32'(dac[0]));
        psel <= 2'h0;
        step(8'hFD);
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        {arst_n, clen_n, psel, awvalid, wvalid, bready, arvalid, rready} = 9'h080;
        {awaddr, araddr, wdata, level, lat} = '0;
        repeat (4) @(posedge clk);
        arst_n <= 1'h1;
        t_reset();
        t_profiles();
        t_host();
        t_closed();
        t_rates();
        t_pause();
        summarize();
    end
    // Whole run needs well under 8000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        summarize();
    end
endmodule
`default_nettype wire
